// ==== hw/ssio_pkg.sv ====
// Constants, register map and carrier types of the serial channel.
// Assumes a 32-bit AXI4-Lite register bus and one system clock.
package ssio_pkg;

  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] DIV_OFF = 8'h04;
  localparam logic [7:0] DATA_OFF = 8'h08;
  localparam logic [7:0] PROT_OFF = 8'h0C;
  localparam logic [7:0] STAT_OFF = 8'h10;
  localparam logic [7:0] MASK_OFF = 8'h14;

  // ------------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------------
  localparam int PROT_UNLOCK_BIT = 2;
  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_OVERLAP_BIT = 1;
  localparam int STAT_W = 2;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] DIV_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [1:0] STAT_RESET = 2'h0;
  localparam logic [1:0] MASK_RESET = 2'h0;

  // ------------------------------------------------------------------
  // Counts
  // ------------------------------------------------------------------
  localparam logic [3:0] LAST_BIT_IDX = 4'h7;
  localparam logic [4:0] PRESC_DIV8_LAST = 5'h07;
  localparam logic [4:0] PRESC_DIV32_LAST = 5'h1F;
  localparam logic [1:0] PRESC_DIV1 = 2'h0;
  localparam logic [1:0] PRESC_DIV8 = 2'h1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef struct packed {
    logic idle_output_level;
    logic clock_source_internal;
    logic lsb_first;
    logic clock_edge_polarity;
    logic pin_function_enable;
    logic output_disable_hiz;
    logic [1:0] clock_prescale_select;
  } ctrl_s;

  typedef struct packed {
    logic sclk_o;
    logic sclk_oe_n;
    logic sout_o;
    logic sout_oe_n;
  } pin_out_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_HOLD = 3'b100
  } xfer_state_e;

endpackage

// ==== hw/ssio_sync.sv ====
// Two-stage synchroniser for levels arriving from pins.
// Assumes the inputs are quasi-static relative to aclk.
module ssio_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_reg;

  // Only the second stage is visible to other logic
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule

// ==== hw/ssio_rate_gen.sv ====
// Prescaler and divisor producing one pulse per half transfer clock.
// Assumes run is low between transfers so each transfer starts clean.
module ssio_rate_gen (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic run,
  input wire logic [1:0] prescale,
  input wire logic [7:0] divisor,
  // Half-period pulse
  output logic half_tick
);

  logic [4:0] pre_reg;
  logic [7:0] div_reg;
  logic base_tick;

  // Undivided, divided by 8 or divided by 32; code 3 also gives 32
  assign base_tick = (prescale == ssio_pkg::PRESC_DIV1) ? 1'b1 :
    (prescale == ssio_pkg::PRESC_DIV8) ?
    (pre_reg[2:0] == ssio_pkg::PRESC_DIV8_LAST[2:0]) :
    (pre_reg == ssio_pkg::PRESC_DIV32_LAST);
  assign half_tick = run && base_tick && (div_reg == divisor);

  // n+1 base ticks per half period gives base/(2(n+1))
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      pre_reg <= 5'h00;
      div_reg <= 8'h00;
    end else begin
      pre_reg <= pre_reg + 5'h01;
      if (base_tick) begin
        div_reg <= (div_reg == divisor) ? 8'h00 : div_reg + 8'h01;
      end
    end
  end

endmodule

// ==== hw/clock_sync_serial_io.sv ====
// 8-bit clock-synchronous serial channel with AXI4-Lite registers.
// Assumes the pins are resolved outside from the output enables.
// Summary of operation
// - Every transfer shifts exactly eight bits out and in.
// - Internal clock is base clock divided by 2(n+1), n from divisor.
// - External source shifts on edges of the serial clock pin.
// - Writing the shift data register starts a transfer.
// - Interrupt on last clock pulse, rising or falling edge by polarity.
// - Option selects LSB-first or MSB-first shifting.
// - With external clock, idle output level is software programmable.
// - Polarity selects which clock edge drives and samples data.
// - Shifting follows clock pulses; internal clock stops after eight.
// - Internal clock: output holds last bit half period, then floats.
// - Internal clock rests high with polarity 0, low with polarity 1.
// - Output-disable bit floats the serial output pin.
// - Pin-function enable gives the pins to data and clock.
// - Between back-to-back bytes the output keeps the last bit with external clock; with internal clock it floats.
//
// Register access over AXI4-Lite and the register addresses were chosen for this implementation.
module clock_sync_serial_io #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  // AXI4-Lite write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read address
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  // AXI4-Lite read data
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Serial pins
  input wire logic serial_clock_pin,
  input wire logic serial_in_pin,
  output ssio_pkg::pin_out_s pins,
  // Interrupt
  output logic irq
);

  // ------------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------------
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    logic [7:0] o;
    o = a[7:0];
    return (o == ssio_pkg::CTRL_OFF) || (o == ssio_pkg::DIV_OFF) ||
      (o == ssio_pkg::DATA_OFF) || (o == ssio_pkg::PROT_OFF) ||
      (o == ssio_pkg::STAT_OFF) || (o == ssio_pkg::MASK_OFF);
  endfunction

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  logic aw_have_reg;
  logic w_have_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;
  ssio_pkg::ctrl_s ctrl_reg;
  logic [7:0] div_reg;
  logic [7:0] shift_reg;
  logic unlock_reg;
  logic [1:0] stat_reg;
  logic [1:0] stat_next;
  logic [1:0] mask_reg;
  ssio_pkg::xfer_state_e state_reg;
  ssio_pkg::xfer_state_e state_next;
  logic [3:0] bit_cnt_reg;
  logic sclk_reg;
  logic sout_reg;
  logic drive_reg;
  logic ext_clk_d_reg;
  logic ext_clk_s;
  logic sin_s;
  logic half_tick;

  // ------------------------------------------------------------------
  // Write channels
  // ------------------------------------------------------------------
  wire wr_go = aw_have_reg && w_have_reg && !bvalid_reg;
  wire wr_en = wr_go && w_strb_reg[0];
  wire [7:0] wr_off = aw_addr_reg[7:0];
  wire [7:0] wr_byte = w_data_reg[7:0];
  wire ssio_pkg::ctrl_s wr_cfg = wr_byte;
  wire wr_ctrl_hit = wr_en && (wr_off == ssio_pkg::CTRL_OFF);
  wire wr_ctrl = wr_ctrl_hit && unlock_reg;
  wire wr_div = wr_en && (wr_off == ssio_pkg::DIV_OFF);
  wire wr_data = wr_en && (wr_off == ssio_pkg::DATA_OFF);
  wire wr_prot = wr_en && (wr_off == ssio_pkg::PROT_OFF);
  wire wr_stat = wr_en && (wr_off == ssio_pkg::STAT_OFF);
  wire wr_mask = wr_en && (wr_off == ssio_pkg::MASK_OFF);

  assign awready = !aw_have_reg && !bvalid_reg;
  assign wready = !w_have_reg && !bvalid_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= ssio_pkg::RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= awaddr;
      end
      if (wvalid && wready) begin
        w_have_reg <= 1'b1;
        w_data_reg <= wdata;
        w_strb_reg <= wstrb;
      end
      if (wr_go) begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= is_mapped(aw_addr_reg) ? ssio_pkg::RESP_OKAY :
          ssio_pkg::RESP_SLVERR;
      end else if (bvalid_reg && bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // Read channel
  // ------------------------------------------------------------------
  wire [7:0] rd_off = araddr[7:0];
  wire [7:0] rd_byte =
    (rd_off == ssio_pkg::CTRL_OFF) ? ctrl_reg :
    (rd_off == ssio_pkg::DIV_OFF) ? div_reg :
    (rd_off == ssio_pkg::DATA_OFF) ? shift_reg :
    (rd_off == ssio_pkg::PROT_OFF) ?
      {5'h00, unlock_reg, 2'h0} :
    (rd_off == ssio_pkg::STAT_OFF) ? {6'h00, stat_reg} :
    (rd_off == ssio_pkg::MASK_OFF) ? {6'h00, mask_reg} : 8'h00;

  assign arready = !rvalid_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= ssio_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= {24'h000000, rd_byte};
      rresp_reg <= is_mapped(araddr) ? ssio_pkg::RESP_OKAY :
        ssio_pkg::RESP_SLVERR;
    end else if (rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------------
  // Any other write spends the unlock, so only the very next one counts
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      unlock_reg <= 1'b0;
      ctrl_reg <= ssio_pkg::CTRL_RESET;
      div_reg <= ssio_pkg::DIV_RESET;
      mask_reg <= ssio_pkg::MASK_RESET;
    end else begin
      if (wr_go) begin
        unlock_reg <= wr_prot && wr_byte[ssio_pkg::PROT_UNLOCK_BIT];
      end
      if (wr_ctrl) begin
        ctrl_reg <= wr_byte;
      end
      if (wr_div) begin
        div_reg <= wr_byte;
      end
      if (wr_mask) begin
        mask_reg <= wr_byte[1:0];
      end
    end
  end

  // ------------------------------------------------------------------
  // Pin synchronisers and clock generation
  // ------------------------------------------------------------------
  ssio_sync #(.W(2)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({serial_clock_pin, serial_in_pin}),
    .q({ext_clk_s, sin_s})
  );

  wire internal = ctrl_reg.clock_source_internal;

  ssio_rate_gen u_rate (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(internal && (state_reg != ssio_pkg::ST_IDLE)),
    .prescale(ctrl_reg.clock_prescale_select),
    .divisor(div_reg),
    .half_tick(half_tick)
  );

  // ------------------------------------------------------------------
  // Shift engine
  // ------------------------------------------------------------------
  // Rest level: high for polarity 0, low for polarity 1
  wire clk_rest = !ctrl_reg.clock_edge_polarity;
  wire running = (state_reg == ssio_pkg::ST_RUN);
  wire int_edge = internal && running && half_tick;
  wire ext_edge = !internal && running && (ext_clk_s != ext_clk_d_reg);
  // Leading edge leaves the rest level and drives data out
  wire lead = (int_edge && (sclk_reg == clk_rest)) ||
    (ext_edge && (ext_clk_s != clk_rest));
  // Trailing edge returns to rest and samples data in
  wire trail = (int_edge && (sclk_reg != clk_rest)) ||
    (ext_edge && (ext_clk_s == clk_rest));
  wire done_evt = trail && (bit_cnt_reg == ssio_pkg::LAST_BIT_IDX);
  wire out_bit = ctrl_reg.lsb_first ? shift_reg[0] : shift_reg[7];
  // A write during a transfer has no buffer to go to and is dropped
  wire start = wr_data && !running;
  wire overlap = wr_data && running;
  wire hold_end = (state_reg == ssio_pkg::ST_HOLD) && half_tick;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ssio_pkg::ST_IDLE: begin
        if (start) begin
          state_next = ssio_pkg::ST_RUN;
        end
      end
      ssio_pkg::ST_RUN: begin
        if (done_evt) begin
          state_next = internal ? ssio_pkg::ST_HOLD :
            ssio_pkg::ST_IDLE;
        end
      end
      ssio_pkg::ST_HOLD: begin
        if (start) begin
          state_next = ssio_pkg::ST_RUN;
        end else if (hold_end) begin
          state_next = ssio_pkg::ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ssio_pkg::ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= ssio_pkg::DATA_RESET;
    end else begin
      state_reg <= state_next;
      if (start) begin
        bit_cnt_reg <= 4'h0;
        shift_reg <= wr_byte;
      end else if (trail) begin
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
        shift_reg <= ctrl_reg.lsb_first ? {sin_s, shift_reg[7:1]} :
          {shift_reg[6:0], sin_s};
      end
    end
  end

  // Serial clock, data output and its drive window
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sclk_reg <= 1'b1;
      sout_reg <= 1'b0;
      drive_reg <= 1'b0;
      ext_clk_d_reg <= 1'b0;
    end else begin
      ext_clk_d_reg <= ext_clk_s;
      if (!running) begin
        sclk_reg <= clk_rest;
      end else if (int_edge) begin
        sclk_reg <= !sclk_reg;
      end
      if (lead) begin
        sout_reg <= out_bit;
      end else if (wr_ctrl && !wr_cfg.clock_source_internal && !running) begin
        sout_reg <= wr_cfg.idle_output_level;
      end
      if (start || hold_end) begin
        drive_reg <= 1'b0;
      end else if (lead) begin
        drive_reg <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // Pins and interrupt
  // ------------------------------------------------------------------
  wire pin_en = ctrl_reg.pin_function_enable;
  wire sout_drive = pin_en && !ctrl_reg.output_disable_hiz &&
    (!internal || drive_reg);

  assign pins.sclk_o = sclk_reg;
  assign pins.sclk_oe_n = !(pin_en && internal);
  assign pins.sout_o = sout_reg;
  assign pins.sout_oe_n = !sout_drive;

  // Set beats a clear arriving in the same cycle
  assign stat_next = (stat_reg & ~(wr_stat ? wr_byte[1:0] : 2'h0)) |
    {overlap, done_evt};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_reg <= ssio_pkg::STAT_RESET;
    end else begin
      stat_reg <= stat_next;
    end
  end

  assign irq = |(stat_reg & mask_reg);

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  property p_eight_bits;
    @(posedge aclk) disable iff (!aresetn)
    done_evt |-> bit_cnt_reg == 4'h7 ##1 bit_cnt_reg == 4'h8;
  endproperty
  a_eight_bits: assert property (p_eight_bits)
    else $error("Transfer did not end after eight bits");

  property p_clk_on_tick;
    @(posedge aclk) disable iff (!aresetn)
    (internal && $past(running) && running && $changed(sclk_reg))
      |-> $past(half_tick);
  endproperty
  a_clk_on_tick: assert property (p_clk_on_tick)
    else $error("Internal clock toggled without a divider tick");

  property p_start;
    @(posedge aclk) disable iff (!aresetn)
    (wr_data && state_reg == ssio_pkg::ST_IDLE) |=>
      running && bit_cnt_reg == 4'h0;
  endproperty
  a_start: assert property (p_start)
    else $error("Data write did not start a transfer");

  property p_irq_flag;
    @(posedge aclk) disable iff (!aresetn)
    done_evt |=> stat_reg[ssio_pkg::STAT_DONE_BIT] && !running;
  endproperty
  a_irq_flag: assert property (p_irq_flag)
    else $error("Completion flag not set on last clock edge");

  property p_stop_after_eight;
    @(posedge aclk) disable iff (!aresetn)
    (internal && done_evt) |=> state_reg == ssio_pkg::ST_HOLD
      ##1 sclk_reg == clk_rest;
  endproperty
  a_stop_after_eight: assert property (p_stop_after_eight)
    else $error("Internal clock did not stop after eight pulses");

  property p_rest_level;
    @(posedge aclk) disable iff (!aresetn)
    (state_reg == ssio_pkg::ST_IDLE && $past(state_reg) ==
      ssio_pkg::ST_IDLE && $stable(ctrl_reg)) |-> sclk_reg == clk_rest;
  endproperty
  a_rest_level: assert property (p_rest_level)
    else $error("Internal clock not at its rest level");

  property p_hiz;
    @(posedge aclk) disable iff (!aresetn)
    ctrl_reg.output_disable_hiz |-> pins.sout_oe_n;
  endproperty
  a_hiz: assert property (p_hiz)
    else $error("Serial output driven while disabled");

  property p_hold_cut;
    @(posedge aclk) disable iff (!aresetn)
    (internal && state_reg == ssio_pkg::ST_HOLD && wr_data) |=>
      pins.sout_oe_n;
  endproperty
  a_hold_cut: assert property (p_hold_cut)
    else $error("Output still driven after write in hold time");

endmodule

// ==== testbench/ssio_peer.sv ====
// Far-side serial device: shifts a byte in and out on the link clock.
// Assumes the bench pulses go after each data write to the channel.
module ssio_peer (
  // Clock
  input wire logic aclk,
  // Channel pins
  input wire ssio_pkg::pin_out_s pins,
  // Setup
  input wire logic ext_mode,
  input wire logic pol,
  input wire logic [7:0] tx_byte,
  input wire logic go,
  // Far side pins
  output logic serial_clock_pin,
  output logic serial_in_pin,
  output logic [7:0] rx_byte
);
  timeunit 1ns;
  timeprecision 1ns;
  logic line, line_q, sout_w, sout_q;
  logic [7:0] tx_sh;
  int cnt;
  // ------------------------------------------------------------------
  // Line resolution
  // ------------------------------------------------------------------
  // A released output shows the inverse of its last level
  assign sout_w = pins.sout_oe_n ? ~sout_q : pins.sout_o;
  assign line = (!ext_mode && !pins.sclk_oe_n) ? pins.sclk_o :
    serial_clock_pin;
  initial begin
    serial_clock_pin = 1'b1;
    serial_in_pin = 1'b0;
    rx_byte = 8'h00;
    cnt = 0;
  end
  // ------------------------------------------------------------------
  // Shifting and clock generation
  // ------------------------------------------------------------------
  always @(posedge aclk) begin
    sout_q <= sout_w;
    line_q <= line;
    if (go) begin
      tx_sh <= tx_byte;
      cnt <= 96;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
    // Exactly sixteen phases of six cycles, then rest level
    if (ext_mode && cnt > 0 && cnt % 6 == 1) begin
      serial_clock_pin <= ~serial_clock_pin;
    end else if (cnt == 0) begin
      serial_clock_pin <= ~pol;
    end
    if (line_q == ~pol && line == pol) begin
      serial_in_pin <= tx_sh[7];
      tx_sh <= {tx_sh[6:0], tx_sh[7]};
    end
    if (line_q == pol && line == ~pol) begin
      rx_byte <= {rx_byte[6:0], sout_w};
    end
  end
endmodule

// ==== testbench/testbench.sv ====
// Self-checking bench for the serial channel over AXI4-Lite.
// Assumes the peer model stands on the serial pins.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 0, aresetn = 0;
  logic [7:0] awaddr = 0, araddr = 0, tx_byte = 0, rx_byte;
  logic [31:0] wdata = 0, rdata;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic ext_mode = 0, pol = 0, go = 0, sclk_q = 1;
  logic awready, wready, bvalid, arready, rvalid, irq, sclk_pin, sin_pin;
  logic [1:0] bresp, rresp;
  ssio_pkg::pin_out_s pins;
  logic [31:0] exp_b[$], exp_r[$];
  int bad_count = 0, checks_done = 0, ncyc = 0, tg = 0, t_last = 0, gap;
  always #25 aclk = ~aclk;
  clock_sync_serial_io u_clock_sync_serial_io (.aclk(aclk),
    .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .serial_clock_pin(sclk_pin), .serial_in_pin(sin_pin), .pins(pins),
    .irq(irq));
  ssio_peer u_ssio_peer (.aclk(aclk), .pins(pins), .ext_mode(ext_mode),
    .pol(pol), .tx_byte(tx_byte), .go(go), .serial_clock_pin(sclk_pin),
    .serial_in_pin(sin_pin), .rx_byte(rx_byte));
  // ------------------------------------------------------------------
  // Checking
  // ------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Responses are compared against the oldest note, in issue order
  always @(negedge aclk) begin
    if (bvalid && bready) check({30'h0, bresp}, exp_b.pop_front());
    if (rvalid && rready) check({rresp, rdata[29:0]}, exp_r.pop_front());
    ncyc++;
    if (pins.sclk_o !== sclk_q) begin
      tg++;
      gap = ncyc - t_last;
      t_last = ncyc;
    end
    sclk_q = pins.sclk_o;
  end
  // ------------------------------------------------------------------
  // Bus tasks
  // ------------------------------------------------------------------
  // Ready is looked at on the falling edge, so the rising edge that
  // takes the item never races the design's own registers
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] r = 2'h0);
    logic ta, tw, tb;
    exp_b.push_back({30'h0, r});
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    tb = 0;
    while (!tb) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] r = 2'h0);
    logic ta, tr;
    exp_r.push_back({r, d[29:0]});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    tr = 0;
    while (!tr) begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
    end
  endtask
  task automatic setup(input logic [7:0] c);
    wr(ssio_pkg::PROT_OFF, 32'h1 << ssio_pkg::PROT_UNLOCK_BIT);
    wr(ssio_pkg::CTRL_OFF, {24'h0, c});
  endtask
  // One spare falling edge lets the toggle monitor count the last edge
  task automatic wait_irq();
    for (int k = 0; k < 9000 && irq !== 1'b1; k++) begin
      @(negedge aclk);
    end
    @(negedge aclk);
    check(irq, 1);
  endtask
  // ------------------------------------------------------------------
  // One byte exchanged with the peer
  // ------------------------------------------------------------------
  task automatic xfer(input logic [7:0] c, input int n, input logic ovl);
    logic [7:0] d, p, dr, pr;
    int half;
    d = 8'($urandom);
    p = 8'($urandom);
    dr = {<<{d}};
    pr = {<<{p}};
    half = (n + 1) * (c[1:0] == 2'h0 ? 1 : c[1:0] == 2'h1 ? 8 : 32);
    pol <= c[4];
    ext_mode <= !c[6];
    tx_byte <= p;
    setup(c);
    wr(ssio_pkg::DIV_OFF, n);
    @(negedge aclk);
    if (!c[6]) check(pins.sout_o, c[7]);
    tg = 0;
    wr(ssio_pkg::DATA_OFF, {24'h0, d});
    if (ovl) wr(ssio_pkg::DATA_OFF, {24'h0, ~d});
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    wait_irq();
    if (c[6]) begin
      check(tg, 16);
      check(gap, half);
      check(pins.sclk_o, !c[4]);
      check(pins.sout_oe_n, 0);
      repeat (half + 2) @(negedge aclk);
      check(pins.sout_oe_n, 1);
    end else begin
      check(pins.sout_o, c[5] ? d[7] : d[0]);
    end
    check(rx_byte, c[5] ? dr : d);
    rd(ssio_pkg::DATA_OFF, c[5] ? pr : p);
    rd(ssio_pkg::STAT_OFF, ovl ? 3 : 1);
    wr(ssio_pkg::MASK_OFF, 0);
    @(negedge aclk);
    check(irq, 0);
    wr(ssio_pkg::MASK_OFF, 1);
    wr(ssio_pkg::STAT_OFF, 3);
    @(negedge aclk);
    check(irq, 0);
  endtask
  // ------------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------------
  initial begin
    void'($urandom(46));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    check(pins.sout_oe_n & pins.sclk_oe_n, 1);
    for (int a = 0; a < 24; a += 4) rd(8'(a), 0);
    rd(8'h18, 0, ssio_pkg::RESP_SLVERR);
    wr(8'h18, 1, ssio_pkg::RESP_SLVERR);
    wr(ssio_pkg::CTRL_OFF, 32'h48);
    rd(ssio_pkg::CTRL_OFF, 0);
    wr(ssio_pkg::MASK_OFF, 1);
    $display("test registers done");
    for (int i = 0; i < 8; i++) begin
      xfer({2'b01, i[0] ^ i[1] ^ i[2], i[2], 2'b10, i[1:0]},
        i[1:0] == 0 ? 4 + $urandom % 4 : $urandom % 3, i == 1);
    end
    // A write in the hold time floats the held bit at once
    wr(ssio_pkg::DATA_OFF, 32'h5A);
    wait_irq();
    check(pins.sout_oe_n, 0);
    wr(ssio_pkg::DATA_OFF, 32'hA5);
    @(negedge aclk);
    check(pins.sout_oe_n, 1);
    wr(ssio_pkg::STAT_OFF, 3);
    wait_irq();
    repeat (200) @(negedge aclk);
    wr(ssio_pkg::STAT_OFF, 3);
    $display("test internal clock done");
    xfer(8'h88, 0, 1'b0);
    xfer(8'h38, 0, 1'b0);
    $display("test external clock done");
    setup(8'h0C);
    @(negedge aclk);
    check(pins.sout_oe_n, 1);
    setup(8'h00);
    @(negedge aclk);
    check(pins.sclk_oe_n & pins.sout_oe_n, 1);
    $display("test pin release done");
    end_sim();
  end
  // Runs out only on a hang; the tests take under 12000 cycles
  initial begin
    #3000000;
    bad_count++;
    end_sim();
  end
endmodule
